/* shared/pei_pkg.sv */
package pei_pkg;
  // sizes of the event block
  localparam int PEI_QUADS = 2;
  localparam int PEI_PORTS = 4;
  localparam int PEI_NPORT = 8;
  localparam int PEI_DET_W = 4;
  localparam int PEI_PON_W = 2;
  localparam int PEI_SUP_W = 8;
  localparam int PEI_ADDR_W = 8;
  localparam int PEI_DATA_W = 8;
  // register offsets, one set per quad
  localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h00;
  localparam logic [7:0] ADDR_IRQ_SUMMARY_ENABLE = 8'h01;
  localparam logic [7:0] ADDR_POWER_CHANGE_EVENTS = 8'h02;
  localparam logic [7:0] ADDR_POWER_CHANGE_EVENTS_CLR = 8'h03;
  localparam logic [7:0] ADDR_CLASS_DETECT_EVENTS = 8'h04;
  localparam logic [7:0] ADDR_CLASS_DETECT_EVENTS_CLR = 8'h05;
  localparam logic [7:0] ADDR_DISCONNECT_POWERCUT_EVENTS = 8'h06;
  localparam logic [7:0] ADDR_DISCONNECT_POWERCUT_EVENTS_CLR = 8'h07;
  localparam logic [7:0] ADDR_OVERCURRENT_START_EVENTS = 8'h08;
  localparam logic [7:0] ADDR_OVERCURRENT_START_EVENTS_CLR = 8'h09;
  localparam logic [7:0] ADDR_SUPPLY_EVENTS = 8'h0A;
  localparam logic [7:0] ADDR_SUPPLY_EVENTS_CLR = 8'h0B;
  localparam logic [7:0] ADDR_TURN_ON_FAULT_CODES = 8'h24;
  localparam logic [7:0] ADDR_TURN_ON_FAULT_CODES_CLR = 8'h25;
  // reset values
  localparam logic [7:0] RST_IRQ_SUMMARY_ENABLE = 8'h80;
  localparam logic [7:0] RST_EVENTS = 8'h00;
  localparam logic [7:0] RST_SUPPLY_EVENTS = 8'h10;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [15:0] RST_DET_PREV = 16'h0000;
  // summary bit positions
  localparam int SUM_SUPPLY = 7;
  localparam int SUM_START = 6;
  localparam int SUM_POWER_CURRENT = 5;
  localparam int SUM_CLASS = 4;
  localparam int SUM_DETECT = 3;
  localparam int SUM_DISCONNECT = 2;
  localparam int SUM_POWER_GOOD = 1;
  localparam int SUM_POWER_ENABLE = 0;
  // supply_events register fields
  localparam int SUP_OSS_BIT = 1;
  localparam int SUP_PCUT_LO = 2;
  localparam int SUP_PCUT_HI = 3;
  localparam int SUP_FAIL_LO = 4;
  localparam int SUP_FAIL_HI = 7;
  // detection result of a good signature
  localparam logic [3:0] VALID_SIGNATURE = 4'h4;
endpackage

/* design/pei_event_irq.sv */
`timescale 1ns/1ps
module pei_event_irq (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_POWER_GOOD,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_POWER_ENABLE,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_DETECT_COMPLETE,
  input wire logic [pei_pkg::PEI_NPORT*pei_pkg::PEI_DET_W-1:0] I_DETECT_STATUS,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_CLASS_COMPLETE,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_MPS_DISCONNECT,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_POWER_CUT_TWO_PAIR,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_OVERCURRENT_TIMEOUT,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_START_FAULT,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_TURN_ON_FAULT_VALID,
  input wire logic [pei_pkg::PEI_NPORT*pei_pkg::PEI_PON_W-1:0] I_TURN_ON_FAULT_CODE,
  input wire logic [pei_pkg::PEI_QUADS*pei_pkg::PEI_SUP_W-1:0] I_SUPPLY_SET,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_SHUTDOWN_MODE,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_PUSHBUTTON_POWER_OFF,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_PUSHBUTTON_PORT_RESET,
  input wire logic [pei_pkg::PEI_NPORT-1:0] I_EMERGENCY_SHUTDOWN,
  input wire logic [pei_pkg::PEI_QUADS-1:0] I_QUAD_RESET,
  input wire logic [pei_pkg::PEI_QUADS-1:0] I_CLEAR_ALL_EVENTS,
  input wire logic I_DETECT_CHANGE_ONLY,
  input wire logic I_REG_QUAD,
  input wire logic [pei_pkg::PEI_ADDR_W-1:0] I_REG_ADDR,
  input wire logic I_REG_RD,
  input wire logic I_REG_WR,
  input wire logic [pei_pkg::PEI_DATA_W-1:0] I_REG_WDATA,
  output logic [pei_pkg::PEI_DATA_W-1:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  output logic O_IRQ_OUT_N
);
  import pei_pkg::*;

  // one port flag into both nibbles of an event register
  function automatic logic [7:0] nib_mask(input logic [3:0] p);
    nib_mask = {p, p};
  endfunction

  // one port flag onto its two-bit code field
  function automatic logic [7:0] pair_mask(input logic [3:0] p);
    pair_mask = {p[3], p[3], p[2], p[2], p[1], p[1], p[0], p[0]};
  endfunction

  // detect done, optionally only on a changed result
  function automatic logic det_event(input logic done, input logic only_chg,
                                     input logic [3:0] now, input logic [3:0] prev);
    det_event = done && (!only_chg || (now != prev));
  endfunction

  // sticky update: a set in the clearing cycle survives
  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] clr,
                                        input logic [7:0] set);
    sticky = (cur & ~clr) | set;
  endfunction

  wire logic [PEI_QUADS*PEI_DATA_W-1:0] rd_all;
  wire logic [PEI_QUADS-1:0] quad_int;
  logic [PEI_DATA_W-1:0] rd_sel;
  wire logic irq_n_next;

  logic [PEI_DATA_W-1:0] rdata_reg;
  logic rvalid_reg;
  logic irq_n_reg;

  genvar q;
  genvar p;
  for (q = 0; q < PEI_QUADS; q++) begin : g_quad
    localparam int LO = q * PEI_PORTS;

    logic [7:0] enable_reg;
    logic [7:0] pwr_reg;
    logic [7:0] cd_reg;
    logic [7:0] dp_reg;
    logic [7:0] os_reg;
    logic [7:0] sup_reg;
    logic [7:0] pon_reg;
    logic [3:0] pg_prev_reg;
    logic [3:0] pe_prev_reg;
    logic [15:0] det_prev_reg;

    wire logic [3:0] pg_now = I_POWER_GOOD[LO +: PEI_PORTS];
    wire logic [3:0] pe_now = I_POWER_ENABLE[LO +: PEI_PORTS];
    wire logic [15:0] det_now = I_DETECT_STATUS[LO*PEI_DET_W +: PEI_PORTS*PEI_DET_W];
    wire logic [3:0] det_set;
    wire logic [3:0] sig_ok;
    wire logic [15:0] det_prev_next;

    // register access for this quad
    wire logic sel = (I_REG_QUAD == 1'(q));
    wire logic rd_hit = I_REG_RD && sel;
    wire logic wr_enable = I_REG_WR && sel && (I_REG_ADDR == ADDR_IRQ_SUMMARY_ENABLE);
    wire logic cor_pwr = rd_hit && (I_REG_ADDR == ADDR_POWER_CHANGE_EVENTS_CLR);
    wire logic cor_cd = rd_hit && (I_REG_ADDR == ADDR_CLASS_DETECT_EVENTS_CLR);
    wire logic cor_dp = rd_hit && (I_REG_ADDR == ADDR_DISCONNECT_POWERCUT_EVENTS_CLR);
    wire logic cor_os = rd_hit && (I_REG_ADDR == ADDR_OVERCURRENT_START_EVENTS_CLR);
    wire logic cor_sup = rd_hit && (I_REG_ADDR == ADDR_SUPPLY_EVENTS_CLR);
    wire logic cor_pon = rd_hit && (I_REG_ADDR == ADDR_TURN_ON_FAULT_CODES_CLR);

    // per-port and whole-quad clears
    wire logic quad_clr = I_QUAD_RESET[q] || I_CLEAR_ALL_EVENTS[q];
    wire logic [3:0] port_clr = I_SHUTDOWN_MODE[LO +: PEI_PORTS]
                              | I_PUSHBUTTON_POWER_OFF[LO +: PEI_PORTS]
                              | I_PUSHBUTTON_PORT_RESET[LO +: PEI_PORTS]
                              | I_EMERGENCY_SHUTDOWN[LO +: PEI_PORTS]
                              | {PEI_PORTS{quad_clr}};
    wire logic oss_now = |I_EMERGENCY_SHUTDOWN[LO +: PEI_PORTS];

    // the power change detectors sample a one-clock-old copy of power good and power enable
    wire logic [3:0] pg_chg = pg_now ^ pg_prev_reg;
    wire logic [3:0] pe_chg = pe_now ^ pe_prev_reg;
    wire logic [7:0] pwr_set = {pg_chg, pe_chg};

    for (p = 0; p < PEI_PORTS; p++) begin : g_port
      wire logic [3:0] det_p = det_now[p*PEI_DET_W +: PEI_DET_W];
      wire logic [3:0] prev_p = det_prev_reg[p*PEI_DET_W +: PEI_DET_W];
      assign det_set[p] = det_event(I_DETECT_COMPLETE[LO+p], I_DETECT_CHANGE_ONLY,
                                    det_p, prev_p);
      assign sig_ok[p] = (det_p == VALID_SIGNATURE);
      assign det_prev_next[p*PEI_DET_W +: PEI_DET_W] = I_DETECT_COMPLETE[LO+p] ? det_p : prev_p;
    end

    // class done without a good signature would be a stale result, so drop it
    wire logic [3:0] cls_set = I_CLASS_COMPLETE[LO +: PEI_PORTS] & sig_ok;
    wire logic [7:0] cd_set = {cls_set, det_set};
    wire logic [7:0] dp_set = {I_MPS_DISCONNECT[LO +: PEI_PORTS],
                               I_POWER_CUT_TWO_PAIR[LO +: PEI_PORTS]};
    wire logic [7:0] os_set = {I_OVERCURRENT_TIMEOUT[LO +: PEI_PORTS],
                               I_START_FAULT[LO +: PEI_PORTS]};
    wire logic [7:0] sup_in = I_SUPPLY_SET[q*PEI_SUP_W +: PEI_SUP_W];
    wire logic [7:0] sup_set = {sup_in[7:2], sup_in[SUP_OSS_BIT] | oss_now, sup_in[0]};
    wire logic [7:0] pon_set = pair_mask(I_TURN_ON_FAULT_VALID[LO +: PEI_PORTS])
                             & I_TURN_ON_FAULT_CODE[LO*PEI_PON_W +: PEI_PORTS*PEI_PON_W];

    // clear masks; the supply register only clears as a whole
    wire logic [7:0] pclr = nib_mask(port_clr);
    wire logic [7:0] pwr_clr = pclr | {8{cor_pwr}};
    wire logic [7:0] cd_clr = pclr | {8{cor_cd}};
    wire logic [7:0] dp_clr = pclr | {8{cor_dp}};
    wire logic [7:0] os_clr = pclr | {8{cor_os}};
    wire logic [7:0] sup_clr = {8{quad_clr | cor_sup}};
    wire logic [7:0] pon_clr = pair_mask(port_clr) | {8{cor_pon}};

    wire logic [7:0] pwr_next = sticky(pwr_reg, pwr_clr, pwr_set);
    wire logic [7:0] cd_next = sticky(cd_reg, cd_clr, cd_set);
    wire logic [7:0] dp_next = sticky(dp_reg, dp_clr, dp_set);
    wire logic [7:0] os_next = sticky(os_reg, os_clr, os_set);
    wire logic [7:0] sup_next = sticky(sup_reg, sup_clr, sup_set);
    wire logic [7:0] pon_next = sticky(pon_reg, pon_clr, pon_set);
    wire logic [7:0] enable_next = wr_enable ? I_REG_WDATA : enable_reg;

    // summary is pure OR of live event bits, so it falls only when all feeders are zero
    wire logic [7:0] summary;
    assign summary[SUM_SUPPLY] = |sup_reg[SUP_FAIL_HI:SUP_FAIL_LO];
    assign summary[SUM_START] = (|os_reg[3:0]) | (|pon_reg);
    assign summary[SUM_POWER_CURRENT] = (|os_reg[7:4]) | (|dp_reg[3:0])
                                      | (|sup_reg[SUP_PCUT_HI:SUP_PCUT_LO]);
    assign summary[SUM_CLASS] = |cd_reg[7:4];
    assign summary[SUM_DETECT] = |cd_reg[3:0];
    assign summary[SUM_DISCONNECT] = (|dp_reg[7:4]) | sup_reg[SUP_OSS_BIT];
    assign summary[SUM_POWER_GOOD] = |pwr_reg[7:4];
    assign summary[SUM_POWER_ENABLE] = |pwr_reg[3:0];

    assign quad_int[q] = |(summary & enable_reg);

    // both copies return the same bits; only the odd address clears
    logic [7:0] rd_q;
    always_comb begin
      if (I_REG_ADDR == ADDR_IRQ_SUMMARY) begin
        rd_q = summary;
      end else if (I_REG_ADDR == ADDR_IRQ_SUMMARY_ENABLE) begin
        rd_q = enable_reg;
      end else if (I_REG_ADDR == ADDR_POWER_CHANGE_EVENTS) begin
        rd_q = pwr_reg;
      end else if (I_REG_ADDR == ADDR_POWER_CHANGE_EVENTS_CLR) begin
        rd_q = pwr_reg;
      end else if (I_REG_ADDR == ADDR_CLASS_DETECT_EVENTS) begin
        rd_q = cd_reg;
      end else if (I_REG_ADDR == ADDR_CLASS_DETECT_EVENTS_CLR) begin
        rd_q = cd_reg;
      end else if (I_REG_ADDR == ADDR_DISCONNECT_POWERCUT_EVENTS) begin
        rd_q = dp_reg;
      end else if (I_REG_ADDR == ADDR_DISCONNECT_POWERCUT_EVENTS_CLR) begin
        rd_q = dp_reg;
      end else if (I_REG_ADDR == ADDR_OVERCURRENT_START_EVENTS) begin
        rd_q = os_reg;
      end else if (I_REG_ADDR == ADDR_OVERCURRENT_START_EVENTS_CLR) begin
        rd_q = os_reg;
      end else if (I_REG_ADDR == ADDR_SUPPLY_EVENTS) begin
        rd_q = sup_reg;
      end else if (I_REG_ADDR == ADDR_SUPPLY_EVENTS_CLR) begin
        rd_q = sup_reg;
      end else if (I_REG_ADDR == ADDR_TURN_ON_FAULT_CODES) begin
        rd_q = pon_reg;
      end else if (I_REG_ADDR == ADDR_TURN_ON_FAULT_CODES_CLR) begin
        rd_q = pon_reg;
      end else begin
        rd_q = READ_ZERO;
      end
    end
    assign rd_all[q*PEI_DATA_W +: PEI_DATA_W] = rd_q;

    // host-written enable; a read in the same cycle still sees the old value
    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        enable_reg <= RST_IRQ_SUMMARY_ENABLE;
      end else begin
        enable_reg <= enable_next;
      end
    end

    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        pwr_reg <= RST_EVENTS;
      end else begin
        pwr_reg <= pwr_next;
      end
    end

    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        cd_reg <= RST_EVENTS;
      end else begin
        cd_reg <= cd_next;
      end
    end

    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        dp_reg <= RST_EVENTS;
      end else begin
        dp_reg <= dp_next;
      end
    end

    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        os_reg <= RST_EVENTS;
      end else begin
        os_reg <= os_next;
      end
    end

    // supply monitor comes up flagged, so the pin asserts until the host reads its clearing copy
    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        sup_reg <= RST_SUPPLY_EVENTS;
      end else begin
        sup_reg <= sup_next;
      end
    end

    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        pon_reg <= RST_EVENTS;
      end else begin
        pon_reg <= pon_next;
      end
    end

    // previous-value copies for the change detectors
    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        pg_prev_reg <= 4'h0;
      end else begin
        pg_prev_reg <= pg_now;
      end
    end

    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        pe_prev_reg <= 4'h0;
      end else begin
        pe_prev_reg <= pe_now;
      end
    end

    always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
        det_prev_reg <= RST_DET_PREV;
      end else begin
        det_prev_reg <= det_prev_next;
      end
    end
  end

  always_comb begin
    if (I_REG_QUAD) begin
      rd_sel = rd_all[PEI_DATA_W +: PEI_DATA_W];
    end else begin
      rd_sel = rd_all[0 +: PEI_DATA_W];
    end
  end
  // pin follows event state one clock late, so a clearing read drops it next edge
  assign irq_n_next = ~(|quad_int);

  // data returns to zero between reads so a stuck strobe shows up
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rdata_reg <= READ_ZERO;
    end else begin
      rdata_reg <= I_REG_RD ? rd_sel : READ_ZERO;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= I_REG_RD;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= irq_n_next;
    end
  end

  assign O_REG_RDATA = rdata_reg;
  assign O_REG_RVALID = rvalid_reg;
  assign O_IRQ_OUT_N = irq_n_reg;
endmodule

/* bench/pei_event_irq_props.sv */
`timescale 1ns/1ps
module pei_event_irq_props (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic [7:0] I_POWER_GOOD,
  input wire logic [7:0] I_POWER_ENABLE,
  input wire logic [7:0] I_DETECT_COMPLETE,
  input wire logic I_DETECT_CHANGE_ONLY,
  input wire logic I_REG_QUAD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_RD,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic O_REG_RVALID,
  input wire logic O_IRQ_OUT_N
);
  import pei_pkg::*;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  sequence s_rd(a);
    I_REG_RD && I_REG_ADDR == a && !I_REG_QUAD;
  endsequence
  // a status toggle between two reads would legally re-set a returned bit
  sequence s_still;
    $stable(I_POWER_GOOD) && $stable(I_POWER_ENABLE);
  endsequence
  a_read_answer_due: assert property (I_REG_RD |=> O_REG_RVALID) else $error("read not answered");
  a_answer_has_cause: assert property (O_REG_RVALID |-> $past(I_REG_RD)) else $error("stray read answer");
  a_idle_data_zero: assert property (!O_REG_RVALID |-> O_REG_RDATA == 8'h00) else $error("data not idle");
  a_unmapped_reads_zero: assert property (I_REG_RD && I_REG_ADDR == 8'h0C |=> O_REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_pin_idle_release: assert property ($fell(I_RST) |-> O_IRQ_OUT_N) else $error("pin low after reset");
  a_pg_change_seen: assert property ((!$past(I_RST) && $changed(I_POWER_GOOD[0])) ##1 s_rd(8'h02)
    |=> O_REG_RDATA[4]) else $error("power good toggle not flagged");
  a_detect_done_seen: assert property ((I_DETECT_COMPLETE[0] && !I_DETECT_CHANGE_ONLY) ##1 s_rd(8'h04)
    |=> O_REG_RDATA[0]) else $error("detect done not flagged");
  a_cor_read_clears: assert property (s_rd(8'h03) ##0 s_still ##1 s_still ##1 s_rd(8'h03)
    |=> (O_REG_RDATA & $past(O_REG_RDATA, 2)) == 8'h00) else $error("returned events not cleared");
endmodule
bind pei_event_irq pei_event_irq_props u_props (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_POWER_GOOD(I_POWER_GOOD),
  .I_POWER_ENABLE(I_POWER_ENABLE), .I_DETECT_COMPLETE(I_DETECT_COMPLETE), .I_DETECT_CHANGE_ONLY(I_DETECT_CHANGE_ONLY),
  .I_REG_QUAD(I_REG_QUAD), .I_REG_ADDR(I_REG_ADDR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
  .O_REG_RVALID(O_REG_RVALID), .O_IRQ_OUT_N(O_IRQ_OUT_N));

/* bench/pei_host_model.sv */
`timescale 1ns/1ps
module pei_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic o_reg_quad,
  output logic [7:0] o_reg_addr,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_quad = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // entered just after a clock edge; answer comes exactly one edge after the taking edge
  task automatic rd(input logic q, input logic [7:0] a, output logic [7:0] d);
    o_reg_rd <= 1'b1;
    o_reg_quad <= q;
    o_reg_addr <= a;
    @(posedge i_mclk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    @(posedge i_mclk);
    d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hXX;
  endtask
  // trailing edge keeps a following write from re-driving the strobe in one step
  task automatic wr(input logic q, input logic [7:0] a, input logic [7:0] v);
    o_reg_wr <= 1'b1;
    o_reg_quad <= q;
    o_reg_addr <= a;
    o_reg_wdata <= v;
    @(posedge i_mclk);
    o_reg_wr <= 1'b0;
    o_reg_wdata <= ~v;
    @(posedge i_mclk);
  endtask
endmodule

/* bench/pse_port_event_interrupts_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); \
  end \
end
module pse_port_event_interrupts_tb;
  import pei_pkg::*;
  logic clk;
  logic rst = 1'b1;
  logic chg = 1'b0;
  logic quad, rd, wr, rvalid, irq_n;
  logic [7:0] addr, wdata, rdata, d;
  logic [7:0] pg = 8'h00, pe = 8'h00, dc = 8'h00, cc = 8'h00, disc = 8'h00, pcut = 8'h00, ilim = 8'h00, sf = 8'h00;
  logic [7:0] sd = 8'h00, pbo = 8'h00, pbr = 8'h00, es = 8'h00;
  logic [1:0] qr = 2'h0, ca = 2'h0;
  logic [31:0] ds = 32'h00000000;
  int errors = 0, checks_done = 0, cycles = 0;
  pei_event_irq uut (.I_MCLK(clk), .I_RST(rst), .I_POWER_GOOD(pg), .I_POWER_ENABLE(pe), .I_DETECT_COMPLETE(dc),
    .I_DETECT_STATUS(ds), .I_CLASS_COMPLETE(cc), .I_MPS_DISCONNECT(disc), .I_POWER_CUT_TWO_PAIR(pcut),
    .I_OVERCURRENT_TIMEOUT(ilim), .I_START_FAULT(sf), .I_TURN_ON_FAULT_VALID(8'h00), .I_TURN_ON_FAULT_CODE(16'h0000),
    .I_SUPPLY_SET(16'h0000), .I_SHUTDOWN_MODE(sd), .I_PUSHBUTTON_POWER_OFF(pbo), .I_PUSHBUTTON_PORT_RESET(pbr),
    .I_EMERGENCY_SHUTDOWN(es), .I_QUAD_RESET(qr), .I_CLEAR_ALL_EVENTS(ca), .I_DETECT_CHANGE_ONLY(chg),
    .I_REG_QUAD(quad), .I_REG_ADDR(addr), .I_REG_RD(rd), .I_REG_WR(wr), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .O_IRQ_OUT_N(irq_n));
  pei_host_model h (.i_mclk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_quad(quad),
    .o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd_chk(input logic q, input logic [7:0] a, input logic [7:0] e);
    h.rd(q, a, d);
    `CHK(d, e)
  endtask
  // pin is registered behind the summary, so let two edges pass first
  task automatic pin_chk(input logic e);
    repeat (2) @(posedge clk);
    `CHK(irq_n, e)
  endtask
  // supply events come up flagged and unmasked, so the pin starts asserted
  task automatic t_reset_vals;
    pin_chk(1'b0);
    for (int q = 0; q < 2; q++) begin
      rd_chk(q[0], 8'h01, RST_IRQ_SUMMARY_ENABLE);
      rd_chk(q[0], 8'h00, 8'h80);
      for (int a = 2; a < 10; a++) rd_chk(q[0], 8'(a), 8'h00);
      rd_chk(q[0], 8'h0B, RST_SUPPLY_EVENTS);
      rd_chk(q[0], 8'h0A, 8'h00);
      rd_chk(q[0], 8'h00, 8'h00);
    end
    rd_chk(1'b0, 8'h0C, 8'h00);
    pin_chk(1'b1);
  endtask
  task automatic t_power;
    h.wr(1'b0, 8'h01, 8'h03);
    pg[0] <= 1'b1;
    pe[3] <= 1'b1;
    @(posedge clk);
    rd_chk(1'b0, 8'h02, 8'h18);
    rd_chk(1'b0, 8'h00, 8'h03);
    pin_chk(1'b0);
    rd_chk(1'b0, 8'h03, 8'h18);
    rd_chk(1'b0, 8'h03, 8'h00);
    rd_chk(1'b0, 8'h00, 8'h00);
    pin_chk(1'b1);
    pg[0] <= 1'b0;
    @(posedge clk);
    rd_chk(1'b0, 8'h02, 8'h10);
    rd_chk(1'b0, 8'h03, 8'h10);
  endtask
  task automatic t_class;
    {dc[1:0], cc[2:1]} <= 4'hF;
    ds[11:0] <= 12'h042;
    @(posedge clk);
    {dc[1:0], cc[2:1]} <= 4'h0;
    rd_chk(1'b0, 8'h04, 8'h23);
    rd_chk(1'b0, 8'h00, 8'h18);
    rd_chk(1'b0, 8'h05, 8'h23);
    chg <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      ds[7:4] <= 4'h4 + 4'(i);
      dc[1] <= 1'b1;
      @(posedge clk);
      dc[1] <= 1'b0;
      rd_chk(1'b0, 8'h04, i ? 8'h02 : 8'h00);
    end
    chg <= 1'b0;
  endtask
  task automatic t_faults;
    {sf[7], ilim[6], pcut[5], disc[4]} <= 4'hF;
    @(posedge clk);
    {sf[7], ilim[6], pcut[5], disc[4]} <= 4'h0;
    rd_chk(1'b1, 8'h06, 8'h12);
    rd_chk(1'b1, 8'h08, 8'h48);
    rd_chk(1'b1, 8'h00, 8'h64);
    pin_chk(1'b1);
    h.wr(1'b1, 8'h01, 8'h04);
    pin_chk(1'b0);
    sd[4] <= 1'b1;
    @(posedge clk);
    sd[4] <= 1'b0;
    rd_chk(1'b1, 8'h06, 8'h02);
    rd_chk(1'b1, 8'h00, 8'h60);
    pin_chk(1'b1);
  endtask
  task automatic t_clears;
    for (int k = 0; k < 6; k++) begin
      disc[0] <= 1'b1;
      @(posedge clk);
      disc[0] <= 1'b0;
      {sd[0], pbo[0], pbr[0], es[0], qr[0], ca[0]} <= 6'h20 >> k;
      @(posedge clk);
      {sd[0], pbo[0], pbr[0], es[0], qr[0], ca[0]} <= 6'h00;
      rd_chk(1'b0, 8'h06, 8'h00);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_vals();
    t_power();
    t_class();
    t_faults();
    t_clears();
    stop_test();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
endmodule
